// *** logic/fpt_flash.v ***
// Serial flash front end: parameter-table reads, power-on gating, write-enable latch.
// Assumes a host drives the serial bus; sclk and cs are sampled by clk (mode 0).
`timescale 1ns/1ns
`include "fpt_regs.vh"
module fpt_flash #(
  parameter READ_DELAY_CYC = `FPT_READ_DELAY_CYC,
  parameter WRITE_DELAY_CYC = `FPT_WRITE_DELAY_CYC,
  parameter DUMMY_CYC = 8
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Supply comparators
  input wire supply_above_inhibit,
  input wire supply_above_min,
  // Lane width: 0 single, 1 dual, 2 quad
  input wire [1:0] lane_mode,
  // Serial bus
  input wire sclk,
  input wire cs_n,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe,
  // Status
  output reg write_enable_latch,
  output wire deep_power_down,
  output wire read_ready,
  output wire write_ready
);
  ////////////////////////////////////////////////////////////////
  localparam ST_CMD = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_DUMMY = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_IGNORE = 3'd4;
  // Lane width codes
  localparam LANE_DUAL = 2'd1;
  localparam LANE_QUAD = 2'd2;

  // Synchronised pins
  wire [3:0] pins_s;
  wire [3:0] io_s;
  wire [1:0] supply_s;
  wire sclk_s = pins_s[0];
  // Select crosses inverted, so the flop reset reads as deselected
  wire cs_n_s = ~pins_s[1];
  wire [1:0] lane_s = pins_s[3:2];
  wire read_ok;
  wire write_ok;
  // Command engine state
  reg sclk_d_q;
  reg [2:0] state_q;
  reg [7:0] shift_q;
  reg [5:0] bitcnt_q;
  reg [7:0] addr_q;
  reg [7:0] out_q;
  reg reset_armed_q;
  reg [3:0] io_out_d;

  // Synchronise every outside input
  // Lane mode rides with the pins; it is static within a frame
  fpt_sync #(.W(4)) u_sync_pins (
    .clk(clk),
    .rstn(rstn),
    .d({lane_mode, ~cs_n, sclk}),
    .q(pins_s)
  );
  fpt_sync #(.W(4)) u_sync_io (
    .clk(clk),
    .rstn(rstn),
    .d(io_in),
    .q(io_s)
  );
  fpt_sync #(.W(2)) u_sync_sup (
    .clk(clk),
    .rstn(rstn),
    .d({supply_above_min, supply_above_inhibit}),
    .q(supply_s)
  );

  fpt_por #(.READ_DELAY_CYC(READ_DELAY_CYC), .WRITE_DELAY_CYC(WRITE_DELAY_CYC)) u_por (
    .clk(clk),
    .rstn(rstn),
    .above_inhibit(supply_s[0]),
    .above_min(supply_s[1]),
    .read_ok(read_ok),
    .write_ok(write_ok)
  );

  // Windows are exported as levels for the host side
  assign read_ready = read_ok;
  assign write_ready = write_ok;
  // never enters deep power-down on power-up
  assign deep_power_down = 1'b0;

  ////////////////////////////////////////////////////////////////
  // Edge detect on the synchronised clock
  // Three edges of sync lag, so each sclk phase must span four clk cycles
  wire rise = sclk_s & ~sclk_d_q;
  wire fall = ~sclk_s & sclk_d_q;
  wire inhibit = ~supply_s[0];

  // Bits per edge by lane mode
  wire [5:0] step = (lane_s == LANE_QUAD) ? 6'd4 : (lane_s == LANE_DUAL) ? 6'd2 : 6'd1;
  wire [7:0] shift_in = (lane_s == LANE_QUAD) ? {shift_q[3:0], io_s[3:0]} :
                        (lane_s == LANE_DUAL) ? {shift_q[5:0], io_s[1:0]} :
                        {shift_q[6:0], io_s[0]};
  wire byte_done = (bitcnt_q + step) == 6'd8;

  function [7:0] table_byte;
    input [7:0] a;
    reg [31:0] dw;
    begin
      dw = `FPT_BLANK_VAL;
      if (a[7:2] == `FPT_SUPPLY_LIMITS_OFS >> 2) begin
        dw = `FPT_SUPPLY_LIMITS_VAL;
      end else if (a[7:2] == `FPT_RESET_WRAP_OFS >> 2) begin
        dw = `FPT_RESET_WRAP_VAL;
      end else if (a[7:2] == `FPT_LOCK_OTP_OFS >> 2) begin
        dw = `FPT_LOCK_OTP_VAL;
      end
      case (a[1:0])
        2'd0: table_byte = dw[7:0];
        2'd1: table_byte = dw[15:8];
        2'd2: table_byte = dw[23:16];
        default: table_byte = dw[31:24];
      endcase
    end
  endfunction

  // Gated opcode classes, held back until the write window opens
  function is_write_cmd;
    input [7:0] op;
    begin
      case (op)
        // Latch and program
        `FPT_OP_WRITE_ENABLE,
        `FPT_OP_PAGE_PROG,
        `FPT_OP_QUAD_PAGE_PROG,
        // Erases of every size
        `FPT_OP_SECTOR_ERASE,
        `FPT_OP_HALF_BLOCK_ERASE,
        `FPT_OP_BLOCK_ERASE,
        `FPT_OP_CHIP_ERASE,
        `FPT_OP_CHIP_ERASE_ALT,
        // Register writes
        `FPT_OP_SECURITY_WRITE,
        `FPT_OP_STATUS_WRITE: is_write_cmd = 1'b1;
        default: is_write_cmd = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Command engine; inhibit acts as a held reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_q <= 1'b0;
      state_q <= ST_CMD;
      shift_q <= 8'h00;
      bitcnt_q <= 6'd0;
      addr_q <= 8'h00;
      out_q <= 8'hff;
      reset_armed_q <= 1'b0;
      write_enable_latch <= 1'b0;
    end else begin
      sclk_d_q <= sclk_s;
      // hold logic in reset below threshold
      if (inhibit) begin
        state_q <= ST_CMD;
        bitcnt_q <= 6'd0;
        reset_armed_q <= 1'b0;
        write_enable_latch <= 1'b0;
      end else if (cs_n_s) begin
        // Deselect ends any frame; an armed reset waits for the next one
        state_q <= ST_CMD;
        bitcnt_q <= 6'd0;
      end else if (rise) begin
        shift_q <= shift_in;
        bitcnt_q <= byte_done ? 6'd0 : bitcnt_q + step;
        case (state_q)
          // Opcode byte decides how the frame is handled
          ST_CMD: begin
            if (byte_done) begin
              // software reset needs the enable first
              reset_armed_q <= (shift_in == `FPT_OP_RESET_EN);
              if (shift_in == `FPT_OP_RESET && reset_armed_q) begin
                write_enable_latch <= 1'b0;
                state_q <= ST_IGNORE;
              // reads once the read delay is over
              end else if (shift_in == `FPT_OP_READ_TABLE && read_ok) begin
                state_q <= ST_ADDR;
              // write class waits for the write delay
              end else if (is_write_cmd(shift_in) && !write_ok) begin
                state_q <= ST_IGNORE;
              end else if (shift_in == `FPT_OP_WRITE_ENABLE) begin
                write_enable_latch <= 1'b1;
                state_q <= ST_IGNORE;
              end else if (shift_in == `FPT_OP_WRITE_DISABLE && read_ok) begin
                write_enable_latch <= 1'b0;
                state_q <= ST_IGNORE;
              end else begin
                // Unknown or refused opcodes just sit out the frame
                state_q <= ST_IGNORE;
              end
            end
          end
          // address on the same lanes as the opcode
          ST_ADDR: begin
            if (byte_done) begin
              addr_q <= shift_in;
              if (DUMMY_CYC == 0) begin
                state_q <= ST_DATA;
                out_q <= table_byte(shift_in);
              end else begin
                state_q <= ST_DUMMY;
              end
              bitcnt_q <= 6'd0;
            end
          end
          // host mode bits and wait cycles pass here
          ST_DUMMY: begin
            if (bitcnt_q == DUMMY_CYC[5:0] - 6'd1) begin
              state_q <= ST_DATA;
              out_q <= table_byte(addr_q);
              bitcnt_q <= 6'd0;
            end else begin
              bitcnt_q <= bitcnt_q + 6'd1;
            end
          end
          // Data phase, next byte preloaded at each byte end
          ST_DATA: begin
            if (byte_done) begin
              addr_q <= addr_q + 8'h01;
              out_q <= table_byte(addr_q + 8'h01);
            end else begin
              out_q <= out_q;
            end
          end
          // Ignored frames shift on unheard until deselect
          default: begin
            bitcnt_q <= 6'd0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output bit index within the current byte
  wire [2:0] hi = 3'd7 - bitcnt_q[2:0];
  always @* begin
    io_out_d = 4'h0;
    // Quad sends the high nibble first
    if (lane_s == LANE_QUAD) begin
      io_out_d = bitcnt_q[2] ? out_q[3:0] : out_q[7:4];
    end else if (lane_s == LANE_DUAL) begin
      io_out_d = {2'b00, out_q[hi -: 2]};
    end else begin
      io_out_d = {2'b00, out_q[hi], 1'b0};
    end
  end

  // Drive data on entering the data phase and on falling edges; release on deselect, inhibit or outside the data phase
  // Released lanes keep their last value; only the enables count
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else if (inhibit || cs_n_s || state_q != ST_DATA) begin
      io_oe <= 4'h0;
    end else if (fall || io_oe == 4'h0) begin
      io_out <= io_out_d;
      io_oe <= (lane_s == LANE_QUAD) ? 4'hf : (lane_s == LANE_DUAL) ? 4'h3 : 4'h2;
    end
  end
endmodule // fpt_flash

// *** logic/fpt_regs.vh ***
// Parameter-table constants, command opcodes and power-on timing for the flash front end.
// Assumes inclusion by bare name from the design modules only.
`ifndef FPT_REGS_VH
`define FPT_REGS_VH

// Table dword byte addresses
`define FPT_SUPPLY_LIMITS_OFS 8'h60
`define FPT_RESET_WRAP_OFS 8'h64
`define FPT_LOCK_OTP_OFS 8'h68
`define FPT_UNUSED_TAIL_OFS 8'h6c

// Table dword contents
`define FPT_SUPPLY_LIMITS_VAL 32'h1650_2000
`define FPT_RESET_WRAP_VAL 32'h64c0_f99c
`define FPT_LOCK_OTP_VAL 32'hffff_c8d9
`define FPT_BLANK_VAL 32'hffff_ffff

// Field positions
`define FPT_RST_OPC_LSB 4
`define FPT_WRAP_BIT 15
`define FPT_LOCK_OPC_LSB 2
`define FPT_LOCK_DEF_BIT 10

// Command opcodes
`define FPT_OP_READ_TABLE 8'h5a
`define FPT_OP_RESET_EN 8'h66
`define FPT_OP_RESET 8'h99
`define FPT_OP_WRITE_ENABLE 8'h06
`define FPT_OP_WRITE_DISABLE 8'h04
`define FPT_OP_STATUS_READ 8'h05
`define FPT_OP_PAGE_PROG 8'h02
`define FPT_OP_QUAD_PAGE_PROG 8'h38
`define FPT_OP_SECTOR_ERASE 8'h20
`define FPT_OP_HALF_BLOCK_ERASE 8'h52
`define FPT_OP_BLOCK_ERASE 8'hd8
`define FPT_OP_CHIP_ERASE 8'h60
`define FPT_OP_CHIP_ERASE_ALT 8'hc7
`define FPT_OP_SECURITY_WRITE 8'h2f
`define FPT_OP_STATUS_WRITE 8'h01

// Power-on delays in microseconds, clock 10 MHz
`define FPT_CLK_MHZ 10
`define FPT_READ_DELAY_US 800
`define FPT_WRITE_DELAY_US 1000
`define FPT_READ_DELAY_CYC (`FPT_READ_DELAY_US * `FPT_CLK_MHZ)
`define FPT_WRITE_DELAY_CYC (`FPT_WRITE_DELAY_US * `FPT_CLK_MHZ)

`endif

// *** logic/fpt_sync.v ***
// Two-stage synchroniser for inputs from outside the clk domain.
// Assumes clk is the only clock; first stage feeds only the second.
`timescale 1ns/1ns
module fpt_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  // Two flops, constant reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // fpt_sync

// *** logic/fpt_por.v ***
// Power-on sequencer: read and write access windows after supply comparators rise.
// Assumes supply flags are already synchronised to clk.
`timescale 1ns/1ns
`include "fpt_regs.vh"
module fpt_por #(
  parameter READ_DELAY_CYC = `FPT_READ_DELAY_CYC,
  parameter WRITE_DELAY_CYC = `FPT_WRITE_DELAY_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Supply comparators, synchronised
  input wire above_inhibit,
  input wire above_min,
  // Access windows
  output reg read_ok,
  output reg write_ok
);
  reg [15:0] rd_cnt_q;
  reg [15:0] wr_cnt_q;

  // Read counter restarts below min or inhibit, write counter only below inhibit; below inhibit nothing is open
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_cnt_q <= 16'h0000;
      wr_cnt_q <= 16'h0000;
      read_ok <= 1'b0;
      write_ok <= 1'b0;
    end else begin
      if (!above_min || !above_inhibit) begin
        rd_cnt_q <= 16'h0000;
        read_ok <= 1'b0;
      end else if (rd_cnt_q >= READ_DELAY_CYC[15:0] - 16'h0001) begin
        read_ok <= 1'b1;
      end else begin
        rd_cnt_q <= rd_cnt_q + 16'h0001;
      end
      if (!above_inhibit) begin
        wr_cnt_q <= 16'h0000;
        write_ok <= 1'b0;
      end else if (wr_cnt_q >= WRITE_DELAY_CYC[15:0] - 16'h0001) begin
        write_ok <= 1'b1;
      end else begin
        wr_cnt_q <= wr_cnt_q + 16'h0001;
      end
    end
  end
endmodule // fpt_por

// *** tb/fpt_flash_chk.sv ***
// Port checker for fpt_flash: power-on windows, gating, bus release.
// Assumes a bind from the bench top; supply inputs may change at any time.
`timescale 1ns/1ns
module fpt_flash_chk #(
  parameter READ_DELAY_CYC = 8000,
  parameter WRITE_DELAY_CYC = 10000
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Supply and bus inputs
  input wire supply_above_inhibit,
  input wire supply_above_min,
  input wire [1:0] lane_mode,
  input wire sclk,
  input wire cs_n,
  input wire [3:0] io_in,
  // Outputs
  input wire [3:0] io_out,
  input wire [3:0] io_oe,
  input wire write_enable_latch,
  input wire deep_power_down,
  input wire read_ready,
  input wire write_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  reg [15:0] rd_cnt_q;
  reg [15:0] wr_cnt_q;
  //////////////////////////////
  // Cycles of supply up; saturating so a long run never wraps
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_cnt_q <= 16'h0000;
      wr_cnt_q <= 16'h0000;
    end else begin
      rd_cnt_q <= (supply_above_min && supply_above_inhibit) ? rd_cnt_q + {15'h0000, ~&rd_cnt_q} : 16'h0000;
      wr_cnt_q <= supply_above_inhibit ? wr_cnt_q + {15'h0000, ~&wr_cnt_q} : 16'h0000;
    end
  end
  a_no_deep_down: assert property (deep_power_down == 1'b0)
    else $error("deep power-down reported");
  a_reset_latch_clear: assert property ($rose(rstn) |-> !write_enable_latch)
    else $error("latch set after reset");
  a_inhibit_quiet: assert property (!supply_above_inhibit [*6] |-> !write_enable_latch && io_oe == 4'h0)
    else $error("activity below inhibit");
  a_inhibit_no_ready: assert property (!supply_above_inhibit [*6] |-> !read_ready && !write_ready)
    else $error("ready below inhibit");
  a_latch_needs_window: assert property ($rose(write_enable_latch) |-> write_ready)
    else $error("latch set before write window");
  a_write_not_early: assert property ($rose(write_ready) |-> wr_cnt_q >= WRITE_DELAY_CYC)
    else $error("write window early");
  a_write_on_time: assert property (wr_cnt_q == WRITE_DELAY_CYC + 8 |-> write_ready)
    else $error("write window late");
  a_drive_needs_read: assert property ($rose(|io_oe) |-> read_ready)
    else $error("drive before read window");
  a_read_not_early: assert property ($rose(read_ready) |-> rd_cnt_q >= READ_DELAY_CYC)
    else $error("read window early");
  a_read_on_time: assert property (rd_cnt_q == READ_DELAY_CYC + 8 |-> read_ready)
    else $error("read window late");
  a_release_deselect: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("bus driven while deselected");
  c_quad_read: cover property (lane_mode == 2'h2 && io_oe == 4'hf);
  c_latch_set: cover property ($rose(write_enable_latch));
  c_latch_clear: cover property ($fell(write_enable_latch) && supply_above_inhibit);
endmodule // fpt_flash_chk

// *** tb/fpt_host_model.sv ***
// Host controller model: frames in mode 0, MSB first, 1, 2 or 4 lanes.
// Assumes tasks start from the bench; sclk stands low between frames.
`timescale 1ns/1ns
module fpt_host_model (
  // Bench clock
  input wire clk,
  // Serial bus
  output reg sclk,
  output reg cs_n,
  output reg [1:0] lane_mode,
  output reg [3:0] io_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe
);
  reg [7:0] rd_q [0:15];
  reg [3:0] oe_seen;
  integer w;
  //////////////////////////////
  // deselected from time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    lane_mode = 2'h0;
    io_in = 4'h5;
  end
  // One bit slot; sampled late in the high phase, clear of sync lag
  task cyc(input [3:0] d, output [3:0] q);
    reg [3:0] bus;
    begin
      sclk = 1'b0;
      io_in = d;
      #400;
      sclk = 1'b1;
      #400;
      // Undriven lanes read as the inverse of the stale value
      bus = ~(io_out ^ io_oe);
      q = (w == 1) ? {3'h0, bus[1]} : (w == 2) ? {2'h0, bus[1:0]} : bus;
      oe_seen = oe_seen | io_oe;
    end
  endtask
  task put(input [7:0] b);
    reg [3:0] q;
    integer i;
    begin
      for (i = 0; i < 8; i = i + w) begin
        cyc(b[7:4] >> (4 - w), q);
        b = b << w;
      end
    end
  endtask
  // same lanes throughout, no mode bits, dummy after address
  task frame(input [1:0] mode, input [7:0] op, input adr_en, input [7:0] adr, input integer n);
    reg [3:0] q;
    reg [7:0] b;
    integer i;
    integer j;
    begin
      @(negedge clk);
      lane_mode = mode;
      w = 1 << mode;
      oe_seen = 4'h0;
      cs_n = 1'b0;
      put(op);
      if (adr_en) begin
        put(adr);
        for (i = 0; i < 8; i = i + 1) cyc(~io_in, q);
      end
      for (j = 0; j < n; j = j + 1) begin
        b = 8'h00;
        for (i = 0; i < 8; i = i + w) begin
          cyc(~io_in, q);
          b = (b << w) | {4'h0, q};
        end
        rd_q[j] = b;
      end
      sclk = 1'b0;
      #400;
      cs_n = 1'b1;
      io_in = ~io_in;
      #800;
    end
  endtask
endmodule // fpt_host_model

// *** tb/test_fpt_flash.sv ***
// Bench top for fpt_flash: power-up gating, table reads, reset pair.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
module test_fpt_flash;
  localparam [127:0] TBL = 128'hffffffff_ffffc8d9_64c0f99c_16502000;
  localparam [79:0] WR_OPS = 80'h06_02_38_20_52_d8_60_c7_2f_01;
  localparam [11:0] OE_EXP = 12'hf32;
  reg clk;
  reg rstn;
  reg supply_above_inhibit;
  reg supply_above_min;
  wire [1:0] lane_mode;
  wire sclk, cs_n, write_enable_latch, deep_power_down, read_ready, write_ready;
  wire [3:0] io_in, io_out, io_oe;
  integer n_fail = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer i;
  integer m;
  fpt_flash #(.READ_DELAY_CYC(50), .WRITE_DELAY_CYC(4000)) u_fpt_flash (
    .clk(clk), .rstn(rstn), .supply_above_inhibit(supply_above_inhibit), .supply_above_min(supply_above_min),
    .lane_mode(lane_mode), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down), .read_ready(read_ready),
    .write_ready(write_ready));
  fpt_host_model u_fpt_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .lane_mode(lane_mode),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  //////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tread(input [1:0] md, input [7:0] a, input integer n);
    u_fpt_host_model.frame(md, 8'h5a, 1'b1, a, n);
  endtask
  task cmd(input [7:0] op);
    u_fpt_host_model.frame(2'h0, op, 1'b0, 8'h00, 0);
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    rstn = 1'b0;
    supply_above_inhibit = 1'b0;
    supply_above_min = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(write_enable_latch, 1'b0);
    chk(deep_power_down, 1'b0);
    tread(2'h0, 8'h60, 1);
    chk(u_fpt_host_model.oe_seen, 4'h0);
    $display("test below_inhibit done");
    @(negedge clk) supply_above_inhibit = 1'b1;
    tread(2'h0, 8'h60, 1);
    chk(u_fpt_host_model.oe_seen, 4'h0);
    @(negedge clk) supply_above_min = 1'b1;
    for (i = 0; i < 200 && read_ready !== 1'b1; i = i + 1) @(negedge clk);
    chk(read_ready, 1'b1);
    tread(2'h0, 8'h60, 4);
    for (i = 0; i < 4; i = i + 1) chk(u_fpt_host_model.rd_q[i], TBL[8*i +: 8]);
    for (i = 0; i < 10; i = i + 1) cmd(WR_OPS[8*i +: 8]);
    chk(write_enable_latch, 1'b0);
    chk(write_ready, 1'b0);
    $display("test early_access done");
    for (i = 0; i < 5000 && write_ready !== 1'b1; i = i + 1) @(negedge clk);
    cmd(8'h06);
    chk(write_enable_latch, 1'b1);
    cmd(8'h99);
    chk(write_enable_latch, 1'b1);
    cmd(8'h66);
    cmd(8'h99);
    chk(write_enable_latch, 1'b0);
    cmd(8'h06);
    cmd(8'h04);
    chk(write_enable_latch, 1'b0);
    $display("test commands done");
    for (m = 0; m < 3; m = m + 1) begin
      tread(m[1:0], 8'h60, 16);
      chk(u_fpt_host_model.oe_seen, OE_EXP[4*m +: 4]);
      for (i = 0; i < 16; i = i + 1) chk(u_fpt_host_model.rd_q[i], TBL[8*i +: 8]);
    end
    tread(2'h1, 8'h5f, 2);
    chk(u_fpt_host_model.rd_q[0], 8'hff);
    chk(u_fpt_host_model.rd_q[1], 8'h00);
    $display("test table done");
    cmd(8'h06);
    @(negedge clk) supply_above_inhibit = 1'b0;
    supply_above_min = 1'b0;
    repeat (8) @(negedge clk);
    chk({write_enable_latch, read_ready, write_ready}, 3'h0);
    tread(2'h0, 8'h60, 1);
    chk(u_fpt_host_model.oe_seen, 4'h0);
    $display("test power_down done");
    conclude;
  end
endmodule // test_fpt_flash
bind fpt_flash fpt_flash_chk #(.READ_DELAY_CYC(READ_DELAY_CYC), .WRITE_DELAY_CYC(WRITE_DELAY_CYC)) u_fpt_flash_chk (
  .clk(clk), .rstn(rstn), .supply_above_inhibit(supply_above_inhibit), .supply_above_min(supply_above_min),
  .lane_mode(lane_mode), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down), .read_ready(read_ready),
  .write_ready(write_ready));
